// ---- ivm_pkg.sv ----
// package of vector map constants for the interrupt vector map block
package ivm_pkg;

  localparam int IVM_NUM_IRQ = 25;
  localparam logic [23:0] IVM_RESET_VEC = 24'h008000;
  localparam logic [23:0] IVM_TRAP_VEC = 24'h008004;
  localparam logic [23:0] IVM_IRQ_BASE = 24'h008008;
  localparam logic [23:0] IVM_RSVD_LO = 24'h00806C;
  localparam logic [23:0] IVM_RSVD_HI = 24'h00807C;
  localparam logic [23:0] IVM_SLOT_BYTES = 24'h000004;

  // irq numbers
  localparam logic [4:0] IVM_IRQ_TLI = 5'h00;
  localparam logic [4:0] IVM_IRQ_AWU = 5'h01;
  localparam logic [4:0] IVM_IRQ_CLK = 5'h02;
  localparam logic [4:0] IVM_IRQ_PA = 5'h03;
  localparam logic [4:0] IVM_IRQ_PB = 5'h04;
  localparam logic [4:0] IVM_IRQ_PC = 5'h05;
  localparam logic [4:0] IVM_IRQ_PD = 5'h06;
  localparam logic [4:0] IVM_IRQ_PE = 5'h07;
  localparam logic [4:0] IVM_IRQ_PF = 5'h08;
  localparam logic [4:0] IVM_IRQ_SPI = 5'h0A;
  localparam logic [4:0] IVM_IRQ_ATIM_UPD = 5'h0B;
  localparam logic [4:0] IVM_IRQ_ATIM_CC = 5'h0C;
  localparam logic [4:0] IVM_IRQ_GTIM_UPD = 5'h0D;
  localparam logic [4:0] IVM_IRQ_GTIM_CC = 5'h0E;
  localparam logic [4:0] IVM_IRQ_SER_TX = 5'h11;
  localparam logic [4:0] IVM_IRQ_SER_RX = 5'h12;
  localparam logic [4:0] IVM_IRQ_I2C = 5'h13;
  localparam logic [4:0] IVM_IRQ_CONV = 5'h16;
  localparam logic [4:0] IVM_IRQ_BTIM = 5'h17;
  localparam logic [4:0] IVM_IRQ_FLASH = 5'h18;

  // wake qualification per irq, bit n = irq n
  localparam logic [24:0] IVM_WAKE_HALT = 25'h00804F8;
  localparam logic [24:0] IVM_WAKE_AHALT = 25'h00804FA;
  // irqs with a source connected
  localparam logic [24:0] IVM_IRQ_USED = 25'h1CE7DFF;

  localparam logic [4:0] IVM_SYNC_RST = 5'h00;
  localparam logic [23:0] IVM_VEC_RST = 24'h008000;

  typedef enum logic [1:0] {
    IVM_MODE_RUN = 2'b00,
    IVM_MODE_HALT = 2'b01,
    IVM_MODE_AHALT = 2'b10
  } ivm_mode_t;

  function automatic logic [23:0] ivm_vec_of(input logic [4:0] irq);
    ivm_vec_of = IVM_IRQ_BASE + {17'h00000, irq, 2'b00};
  endfunction

endpackage

// ---- ivm_pin_sync.sv ----
// three-stage pin synchroniser with agreement of the last two stages
module ivm_pin_sync
  import ivm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic pin,
  output logic level
);

  typedef struct packed {
    logic [2:0] stage;
    logic level;
  } ivm_sync_t;

  ivm_sync_t q;
  ivm_sync_t next_q;

  always_comb begin
    next_q = q;
    next_q.stage = {q.stage[1:0], pin};
    // stage 0 only feeds stage 1
    if (q.stage[1] == q.stage[2]) begin
      next_q.level = q.stage[2];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign level = q.level;

endmodule

// ---- ivm_vector_map.sv ----
// interrupt vector map with wakeup qualification
// Function
// - reset 8000, trap 8004, reset wakes always
// - top level line irq0, no wake
// - auto wakeup irq1 wakes active-halt only
// - port a irq3 wakes, except pin one
// - port b irq4 wakes both modes
// - port c irq5 wakes both modes
// - port d irq6 wakes both modes
// - port e irq7 wakes both modes
// - port f irq8 never wakes
// - spi irq10, two-wire irq19 wake both
// - other peripherals vectored, never wake
// - converter shares irq22, no wake
// - unused irqs idle, reserved vectors unused
module ivm_vector_map
  import ivm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [1:0] power_mode,
  input wire logic trap_req,
  input wire logic top_level_ext_irq,
  input wire logic auto_wakeup_unit,
  input wire logic clock_ctrl_irq,
  input wire logic port_a_ext_irq,
  input wire logic port_a_pin_one,
  input wire logic port_b_ext_irq,
  input wire logic port_c_ext_irq,
  input wire logic port_d_ext_irq,
  input wire logic port_e_ext_irq,
  input wire logic port_f_ext_irq,
  input wire logic spi_end_of_transfer,
  input wire logic advanced_timer_update,
  input wire logic advanced_timer_capture,
  input wire logic general_timer_update,
  input wire logic general_timer_capture,
  input wire logic serial_port_tx_done,
  input wire logic serial_port_rx_full,
  input wire logic i2c_irq,
  input wire logic converter_end_of_conv,
  input wire logic converter_watchdog,
  input wire logic basic_timer_update,
  input wire logic end_of_programming,
  input wire logic protected_page_write_attempt,
  input wire logic [24:0] irq_enable,
  output logic vec_valid,
  output logic [23:0] vec_addr,
  output logic [4:0] vec_irq,
  output logic vec_is_trap,
  output logic wake_req
);

  // ****************************************
  // pin synchronisers for external lines
  // ****************************************
  logic [5:0] ext_pin;
  logic [5:0] ext_sync;
  logic pa1_sync;
  logic tli_sync;

  assign ext_pin = {port_f_ext_irq, port_e_ext_irq, port_d_ext_irq,
    port_c_ext_irq, port_b_ext_irq, port_a_ext_irq};

  for (genvar g = 0; g < 6; g++) begin : g_ext
    ivm_pin_sync u_sync (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .pin(ext_pin[g]),
      .level(ext_sync[g])
    );
  end

  ivm_pin_sync u_pa1 (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pin(port_a_pin_one),
    .level(pa1_sync)
  );

  ivm_pin_sync u_tli (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pin(top_level_ext_irq),
    .level(tli_sync)
  );

  // ****************************************
  // helper functions
  // ****************************************
  typedef struct packed {
    logic found;
    logic [4:0] irq;
  } ivm_pick_t;

  // lowest pending number wins
  function automatic ivm_pick_t ivm_pick_lowest(input logic [24:0] pend);
    ivm_pick_t best;
    best = '0;
    for (int i = IVM_NUM_IRQ - 1; i >= 0; i--) begin
      if (pend[i]) begin
        best.found = 1'b1;
        best.irq = 5'(i);
      end
    end
    return best;
  endfunction

  // sources qualified to wake in the given power mode
  function automatic logic [24:0] ivm_wake_mask(input logic [1:0] mode);
    logic [24:0] mask;
    mask = '0;
    unique case (mode)
      IVM_MODE_HALT: mask = IVM_WAKE_HALT;
      IVM_MODE_AHALT: mask = IVM_WAKE_AHALT;
      default: mask = '0;
    endcase
    return mask;
  endfunction

  // slot vectors must stay clear of the reserved area
  function automatic logic ivm_in_rsvd(input logic [23:0] addr);
    return (addr >= IVM_RSVD_LO) && (addr <= IVM_RSVD_HI);
  endfunction

  // ****************************************
  // request vector by irq number
  // ****************************************
  logic [24:0] req;
  logic [24:0] wake_src;

  always_comb begin
    req = '0;
    req[IVM_IRQ_TLI] = tli_sync;
    req[IVM_IRQ_AWU] = auto_wakeup_unit;
    req[IVM_IRQ_CLK] = clock_ctrl_irq;
    req[IVM_IRQ_PA] = ext_sync[0];
    req[IVM_IRQ_PB] = ext_sync[1];
    req[IVM_IRQ_PC] = ext_sync[2];
    req[IVM_IRQ_PD] = ext_sync[3];
    req[IVM_IRQ_PE] = ext_sync[4];
    req[IVM_IRQ_PF] = ext_sync[5];
    req[IVM_IRQ_SPI] = spi_end_of_transfer;
    req[IVM_IRQ_ATIM_UPD] = advanced_timer_update;
    req[IVM_IRQ_ATIM_CC] = advanced_timer_capture;
    req[IVM_IRQ_GTIM_UPD] = general_timer_update;
    req[IVM_IRQ_GTIM_CC] = general_timer_capture;
    req[IVM_IRQ_SER_TX] = serial_port_tx_done;
    req[IVM_IRQ_SER_RX] = serial_port_rx_full;
    req[IVM_IRQ_I2C] = i2c_irq;
    req[IVM_IRQ_CONV] = converter_end_of_conv | converter_watchdog;
    req[IVM_IRQ_BTIM] = basic_timer_update;
    req[IVM_IRQ_FLASH] = end_of_programming | protected_page_write_attempt;
    req = req & IVM_IRQ_USED & irq_enable;
  end

  always_comb begin
    wake_src = req & ivm_wake_mask(power_mode);
    // port a wake is withheld whenever pin one is high, even if port a also requests
    if (pa1_sync) begin
      wake_src[IVM_IRQ_PA] = 1'b0;
    end
  end

  // ****************************************
  // selection and registered outputs
  // ****************************************
  typedef struct packed {
    logic vec_valid;
    logic [23:0] vec_addr;
    logic [4:0] vec_irq;
    logic vec_is_trap;
    logic wake_req;
  } ivm_state_t;

  ivm_state_t q;
  ivm_state_t next_q;
  ivm_pick_t pick;

  assign pick = ivm_pick_lowest(req);

  always_comb begin
    next_q = q;
    next_q.vec_valid = 1'b0;
    next_q.vec_is_trap = 1'b0;
    next_q.vec_irq = IVM_SYNC_RST;
    next_q.vec_addr = IVM_VEC_RST;
    next_q.wake_req = |wake_src;
    // trap outranks every irq
    if (trap_req) begin
      next_q.vec_valid = 1'b1;
      next_q.vec_is_trap = 1'b1;
      next_q.vec_addr = IVM_TRAP_VEC;
    end else if (pick.found && !ivm_in_rsvd(ivm_vec_of(pick.irq))) begin
      // lowest number wins; reserved area never selected
      next_q.vec_valid = 1'b1;
      next_q.vec_irq = pick.irq;
      next_q.vec_addr = ivm_vec_of(pick.irq);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '{
        vec_valid: 1'b0,
        vec_addr: IVM_VEC_RST,
        vec_irq: IVM_SYNC_RST,
        vec_is_trap: 1'b0,
        wake_req: 1'b0
      };
    end else begin
      q <= next_q;
    end
  end

  assign vec_valid = q.vec_valid;
  assign vec_addr = q.vec_addr;
  assign vec_irq = q.vec_irq;
  assign vec_is_trap = q.vec_is_trap;
  assign wake_req = q.wake_req;

endmodule

// ---- ivm_vector_map_properties.sv ----
// checker of vector map output relations
module ivm_vector_map_chk
  import ivm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [1:0] power_mode,
  input wire logic trap_req,
  input wire logic auto_wakeup_unit,
  input wire logic spi_end_of_transfer,
  input wire logic i2c_irq,
  input wire logic [24:0] irq_enable,
  input wire logic vec_valid,
  input wire logic [23:0] vec_addr,
  input wire logic [4:0] vec_irq,
  input wire logic vec_is_trap,
  input wire logic wake_req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  trap_vec_a: assert property (vec_is_trap |-> vec_addr == 24'h008004 && vec_irq == 5'h00)
    else $error("trap vector wrong");
  trap_first_a: assert property (trap_req |=> vec_is_trap && vec_valid)
    else $error("trap not presented");
  idle_vec_a: assert property (!vec_valid |-> vec_addr == 24'h008000)
    else $error("idle vector wrong");
  slot_addr_a: assert property (vec_valid && !vec_is_trap |->
    vec_addr == 24'h008008 + {17'h00000, vec_irq, 2'h0})
    else $error("slot address wrong");
  rsvd_vec_a: assert property (vec_valid |-> vec_addr < 24'h00806C)
    else $error("reserved vector used");
  unused_irq_a: assert property (vec_valid && !vec_is_trap |->
    vec_irq inside {[5'h00:5'h18]} && !(vec_irq inside {5'h09, 5'h0F, 5'h10, 5'h14, 5'h15}))
    else $error("unconnected irq presented");
  run_no_wake_a: assert property (power_mode inside {2'h0, 2'h3} |=> !wake_req)
    else $error("wake while running");
  spi_wake_a: assert property (spi_end_of_transfer && irq_enable[10] && power_mode == 2'h1
    |=> wake_req)
    else $error("spi did not wake");
  i2c_wake_a: assert property (i2c_irq && irq_enable[19] && power_mode == 2'h2
    |=> wake_req)
    else $error("two-wire did not wake");
  awu_wake_a: assert property (auto_wakeup_unit && irq_enable[1] && power_mode == 2'h2
    |=> wake_req)
    else $error("auto wakeup did not wake");
endmodule
bind ivm_vector_map ivm_vector_map_chk i_chk (.*);

// ---- ivm_core_model.sv ----
// core model that sleeps on command and leaves sleep after a wake request
module ivm_core_model
  import ivm_pkg::*;
#(parameter int WAKE_LAT = 12)
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [1:0] mode_req,
  input wire logic go,
  input wire logic wake_req,
  output logic [1:0] power_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      power_mode <= 2'h0;
      cnt <= 0;
    end else if (go) begin
      power_mode <= mode_req;
      cnt <= 0;
    end else if (wake_req && power_mode != 2'h0) begin
      cnt <= cnt + 1;
      if (cnt == WAKE_LAT) power_mode <= 2'h0;
    end
  end
endmodule

// ---- tb_top.sv ----
// self-checking bench of the interrupt vector map
`define CHK(n, e, s) begin total_checks++; if ((e) !== (s)) begin num_errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb_top;
  import ivm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, rst_b = 0, go = 0, smp = 0, sel = 0, trap_req = 0, port_a_pin_one = 0;
  logic [24:0] r = 0, irq_enable = 0;
  logic [1:0] mreq = 0, power_mode;
  logic vec_valid, vec_is_trap, wake_req;
  logic [23:0] vec_addr;
  logic [4:0] vec_irq;
  logic [31:0] e, q[$];
  int num_errors = 0, total_checks = 0, cyc = 0;
  always #5 sys_clk = ~sys_clk;
  ivm_core_model i_core (.sys_clk, .rst_b, .mode_req(mreq), .go, .wake_req, .power_mode);
  ivm_vector_map i_dut (.*, .top_level_ext_irq(r[0]), .auto_wakeup_unit(r[1]),
    .clock_ctrl_irq(r[2]), .port_a_ext_irq(r[3]), .port_b_ext_irq(r[4]), .port_c_ext_irq(r[5]),
    .port_d_ext_irq(r[6]), .port_e_ext_irq(r[7]), .port_f_ext_irq(r[8]),
    .spi_end_of_transfer(r[10]), .advanced_timer_update(r[11]), .advanced_timer_capture(r[12]),
    .general_timer_update(r[13]), .general_timer_capture(r[14]), .serial_port_tx_done(r[17]),
    .serial_port_rx_full(r[18]), .i2c_irq(r[19]), .converter_end_of_conv(r[22] & sel),
    .converter_watchdog(r[22] & ~sel), .basic_timer_update(r[23]),
    .end_of_programming(r[24] & ~sel), .protected_page_write_attempt(r[24] & sel));
  function automatic logic [31:0] ex(input logic [24:0] a, b, input logic [1:0] m,
    input logic x, y);
    logic [24:0] p, w;
    logic [4:0] n;
    p = a & b & 25'h1CE7DFF;
    n = 5'h00;
    for (int i = 24; i >= 0; i--) if (p[i]) n = 5'(i);
    w = (m == 2'h1) ? 25'h00804F8 : (m == 2'h2) ? 25'h00804FA : 25'h0000000;
    w[3] = w[3] & ~x;
    return {y | (|p), y, y ? 5'h00 : n, |(p & w),
      y ? 24'h008004 : (|p) ? 24'h008008 + {17'h00000, n, 2'h0} : 24'h008000};
  endfunction
  task automatic run(input logic [24:0] a, b, input logic [1:0] m, input logic x, y, z);
    @(posedge sys_clk);
    r <= a;
    irq_enable <= b;
    mreq <= m;
    port_a_pin_one <= x;
    trap_req <= y;
    sel <= z;
    go <= 1;
    @(posedge sys_clk);
    go <= 0;
    repeat (5) @(posedge sys_clk);
    q.push_back(ex(a, b, m, x, y));
    smp <= 1;
    @(posedge sys_clk);
    smp <= 0;
  endtask
  task automatic give_verdict;
    if (num_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    if (smp) begin
      e = q.pop_front();
      `CHK("addr", e[23:0], vec_addr)
      `CHK("wake", e[24], wake_req)
      `CHK("irq", e[29:25], vec_irq)
      `CHK("flags", e[31:30], {vec_valid, vec_is_trap})
    end
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      give_verdict;
    end
  end
  initial begin
    void'($urandom(32'hE75171A8));
    repeat (10) @(posedge sys_clk);
    rst_b <= 1;
    for (int i = 0; i < 50; i++) run(25'h1 << (i / 2), 25'h1FFFFFF, 2'(i % 2 + 1), 0, 0, 0);
    rst_b <= 0;
    q.push_back(32'h00008000);
    @(posedge sys_clk);
    smp <= 1;
    @(posedge sys_clk);
    smp <= 0;
    rst_b <= 1;
    run(25'h0000008, 25'h1FFFFFF, 2'h2, 1, 0, 0);
    for (int i = 0; i < 40; i++)
      run(25'($urandom), 25'($urandom), 2'($urandom), 1'($urandom), ($urandom % 4) == 0,
        1'($urandom));
    give_verdict;
  end
endmodule
